//--- logic/vcdec_consts.vh
// Constants for the voltage code decoder and its transition supervision.
`ifndef VCDEC_CONSTS_VH
`define VCDEC_CONSTS_VH

// ----------------------------------------------------------------------------
// Code map
// ----------------------------------------------------------------------------
`define VC_CODE_W 8
`define VC_CODE_TOP 8'h78
`define VC_CODE_BOTTOM 8'hb2
`define VC_CODE_OFF_A 8'hfe
`define VC_CODE_OFF_B 8'hff
// Reference is counted in 6.25 mV steps; 0x50 steps is 0.50000 V.
`define VC_LEVEL_AT_BOTTOM 8'h50
`define VC_LEVEL_RESET 8'h00
`define VC_LEVEL_STEP 8'h01

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define VC_CLK_MHZ 100
`define VC_CLK_PERIOD_NS 10
`define VC_LP_HOLD_US 50
`define VC_STEP_INTERVAL_NS 1000
// Cycle counts at the 100 MHz clock: a 50 us hold and a 1 us step interval.
`define VC_LP_HOLD_CYCLES 16'h1388
`define VC_STEP_CYCLES 16'h0064
`define VC_CNT_W 16
`define VC_CNT_ZERO 16'h0000
`define VC_CNT_ONE 16'h0001

`endif

//--- logic/vcdec_decode.v
// Combinational decode of the voltage code into a reference level.
`default_nettype none
`include "vcdec_consts.vh"

module vcdec_decode
(
  input wire [`VC_CODE_W-1:0] code,
  output reg in_range,
  output reg is_off,
  output reg [`VC_CODE_W-1:0] level
);

  // --------------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------------
  // Codes above the covered range other than 0xfe and 0xff belong to another table and are reported
  // as neither in range nor off, so the caller can hold its last target.
  always @*
  begin
    in_range = (code >= `VC_CODE_TOP) && (code <= `VC_CODE_BOTTOM);
    is_off = (code == `VC_CODE_OFF_A) || (code == `VC_CODE_OFF_B);
    level = `VC_LEVEL_RESET;
    if (in_range)
    begin
      level = `VC_LEVEL_AT_BOTTOM + (`VC_CODE_BOTTOM - code);
    end
  end

endmodule // vcdec_decode
`default_nettype wire

//--- logic/vcdec_top.v
// Voltage code decoder with reference stepping and transition supervision.
`default_nettype none
`include "vcdec_consts.vh"

module vcdec_top
#(
  parameter [`VC_CNT_W-1:0] LP_HOLD_CYCLES = `VC_LP_HOLD_CYCLES,
  parameter [`VC_CNT_W-1:0] STEP_CYCLES = `VC_STEP_CYCLES
)
(
  input wire clk,
  input wire rst_b,
  input wire [`VC_CODE_W-1:0] voltage_code,
  input wire low_power_request_n,
  input wire enable_in,
  output reg [`VC_CODE_W-1:0] ref_level,
  output reg regulating,
  output reg shutdown,
  output reg transition_active,
  output reg overcurrent_protect_raised,
  output reg overvoltage_protect_max,
  output reg low_power_mode
);

  // --------------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_REG = 2'b01;
  localparam [1:0] ST_SHUT = 2'b10;

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  reg rst_meta;
  reg rst_sync_b;

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta <= 1'b0;
      rst_sync_b <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync_b <= rst_meta;
    end
  end

  // --------------------------------------------------------------------------
  // Code sampling and decode
  // --------------------------------------------------------------------------
  reg [`VC_CODE_W-1:0] code_q;
  // Set once the pins have been sampled after reset; the reset value of the
  // sampled code must not be taken for an OFF request.
  reg code_valid;
  wire dec_in_range;
  wire dec_off;
  wire [`VC_CODE_W-1:0] dec_level;

  vcdec_decode u_decode
  (
    .code(code_q),
    .in_range(dec_in_range),
    .is_off(dec_off),
    .level(dec_level)
  );

  // Moves the reference one 6.25 mV step toward the target.
  function [`VC_CODE_W-1:0] step_toward;
    input [`VC_CODE_W-1:0] cur;
    input [`VC_CODE_W-1:0] tgt;
    begin
      if (cur < tgt)
        step_toward = cur + `VC_LEVEL_STEP;
      else if (cur > tgt)
        step_toward = cur - `VC_LEVEL_STEP;
      else
        step_toward = cur;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Control
  // --------------------------------------------------------------------------
  reg [1:0] state;
  reg [1:0] next_state;
  reg [`VC_CODE_W-1:0] target;
  reg [`VC_CODE_W-1:0] next_target;
  reg [`VC_CODE_W-1:0] next_ref_level;
  reg [`VC_CNT_W-1:0] step_cnt;
  reg [`VC_CNT_W-1:0] next_step_cnt;
  reg [`VC_CNT_W-1:0] hold_cnt;
  reg [`VC_CNT_W-1:0] next_hold_cnt;
  reg next_transition;
  reg next_rising;
  reg next_low_power;

  always @*
  begin
    next_state = state;
    next_target = target;
    next_ref_level = ref_level;
    next_step_cnt = step_cnt;
    next_hold_cnt = hold_cnt;
    case (state)
      ST_IDLE:
      begin
        // Nothing starts until a real code has been taken from the pins.
        if (code_valid && enable_in && dec_off)
        begin
          next_state = ST_SHUT;
        end
        else if (code_valid && enable_in && dec_in_range)
        begin
          next_state = ST_REG;
          next_target = dec_level;
          next_ref_level = dec_level;
          next_step_cnt = STEP_CYCLES;
        end
      end
      ST_REG:
      begin
        if (!enable_in)
        begin
          next_state = ST_IDLE;
          next_ref_level = `VC_LEVEL_RESET;
        end
        else if (dec_off)
        begin
          next_state = ST_SHUT;
          next_ref_level = `VC_LEVEL_RESET;
        end
        else
        begin
          // Unsupported codes keep the last good target rather than jumping.
          if (dec_in_range)
            next_target = dec_level;
          // One step per interval keeps the move controlled even if the
          // processor skips steps; the analog smoothing does the rest.
          if (ref_level != target)
          begin
            if (step_cnt <= `VC_CNT_ONE)
            begin
              next_ref_level = step_toward(ref_level, target);
              next_step_cnt = STEP_CYCLES;
            end
            else
              next_step_cnt = step_cnt - `VC_CNT_ONE;
          end
          else
            next_step_cnt = STEP_CYCLES;
        end
      end
      ST_SHUT:
      begin
        // A new code alone never restarts the block; only dropping enable does.
        next_ref_level = `VC_LEVEL_RESET;
        if (!enable_in)
          next_state = ST_IDLE;
      end
      default:
      begin
        next_state = ST_IDLE;
        next_ref_level = `VC_LEVEL_RESET;
      end
    endcase
    // Flags are taken from next values so that they change in the same cycle as
    // the reference and target they describe, at the cost of a longer path.
    next_transition = (next_state == ST_REG) && (next_ref_level != next_target);
    next_rising = next_transition && (next_target > next_ref_level);
    // Low-power operation resumes only after a quiet hold following a move.
    if (next_transition)
      next_hold_cnt = LP_HOLD_CYCLES;
    else if (hold_cnt != `VC_CNT_ZERO)
      next_hold_cnt = hold_cnt - `VC_CNT_ONE;
    // The request pin is a level; the grant waits for a settled reference and
    // an expired hold so that a late request cannot cut into a move.
    next_low_power = (next_state == ST_REG) && !low_power_request_n &&
      !next_transition && (next_hold_cnt == `VC_CNT_ZERO);
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      code_q <= `VC_CODE_OFF_B;
      code_valid <= 1'b0;
      state <= ST_IDLE;
      target <= `VC_LEVEL_RESET;
      ref_level <= `VC_LEVEL_RESET;
      step_cnt <= `VC_CNT_ZERO;
      hold_cnt <= `VC_CNT_ZERO;
      regulating <= 1'b0;
      shutdown <= 1'b0;
      transition_active <= 1'b0;
      overcurrent_protect_raised <= 1'b0;
      overvoltage_protect_max <= 1'b0;
      low_power_mode <= 1'b0;
    end
    else
    begin
      code_q <= voltage_code;
      code_valid <= 1'b1;
      state <= next_state;
      target <= next_target;
      ref_level <= next_ref_level;
      step_cnt <= next_step_cnt;
      hold_cnt <= next_hold_cnt;
      regulating <= (next_state == ST_REG);
      shutdown <= (next_state == ST_SHUT);
      transition_active <= next_transition;
      overcurrent_protect_raised <= next_rising;
      overvoltage_protect_max <= next_transition;
      low_power_mode <= next_low_power;
    end
  end

endmodule // vcdec_top
`default_nettype wire

//--- sim/vcdec_chk.sv
// Port checker for the voltage code decoder.
`default_nettype none
module vcdec_chk
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] voltage_code,
  input wire logic low_power_request_n,
  input wire logic enable_in,
  input wire logic [7:0] ref_level,
  input wire logic regulating,
  input wire logic shutdown,
  input wire logic transition_active,
  input wire logic overcurrent_protect_raised,
  input wire logic overvoltage_protect_max,
  input wire logic low_power_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_ov_max; overvoltage_protect_max == transition_active; endproperty
  a_ov_max: assert property (p_ov_max) else $error("overvoltage level wrong");
  property p_ov_move;
    regulating && $past(regulating) && ref_level != $past(ref_level)
      |-> $past(overvoltage_protect_max);
  endproperty
  a_ov_move: assert property (p_ov_move) else $error("moved at normal level");
  property p_oc_raise; overcurrent_protect_raised |-> transition_active; endproperty
  a_oc_raise: assert property (p_oc_raise) else $error("overcurrent raised when idle");
  property p_oc_up;
    regulating && $past(regulating) && ref_level > $past(ref_level)
      |-> $past(overcurrent_protect_raised);
  endproperty
  a_oc_up: assert property (p_oc_up) else $error("rise at normal trip");
  property p_off; shutdown |-> ref_level == 8'h00 && !regulating; endproperty
  a_off: assert property (p_off) else $error("reference while off");
  property p_rng; regulating |-> ref_level >= 8'h50 && ref_level <= 8'h8a; endproperty
  a_rng: assert property (p_rng) else $error("reference out of range");
  property p_step;
    regulating && $past(regulating) && ref_level != $past(ref_level)
      |-> ref_level == $past(ref_level) + 8'h01 || ref_level == $past(ref_level) - 8'h01;
  endproperty
  a_step: assert property (p_step) else $error("reference jumped");
  property p_lp;
    low_power_mode |-> regulating && !transition_active && !$past(low_power_request_n);
  endproperty
  a_lp: assert property (p_lp) else $error("low power in move");
  property p_go_off;
    regulating && enable_in && voltage_code >= 8'hfe |-> ##[1:3] shutdown;
  endproperty
  a_go_off: assert property (p_go_off) else $error("off code ignored");
  property p_stay; shutdown && enable_in |=> shutdown; endproperty
  a_stay: assert property (p_stay) else $error("left shutdown");
  c_off: cover property (shutdown);
  c_oc_raise: cover property (overcurrent_protect_raised);
  c_lp: cover property (low_power_mode);
endmodule // vcdec_chk
bind vcdec_top vcdec_chk u_chk (.clk(clk), .rst_b(rst_b), .voltage_code(voltage_code),
  .low_power_request_n(low_power_request_n), .enable_in(enable_in), .ref_level(ref_level),
  .regulating(regulating), .shutdown(shutdown), .transition_active(transition_active),
  .overcurrent_protect_raised(overcurrent_protect_raised),
  .overvoltage_protect_max(overvoltage_protect_max), .low_power_mode(low_power_mode));
`default_nettype wire

//--- sim/vcdec_cpu_model.sv
// Processor model driving the voltage code and the low-power request.
`default_nettype none
module vcdec_cpu_model
#(
  parameter int GAP = 8,
  parameter int LP_GAP = 20
)
(
  input wire logic clk,
  output logic [7:0] voltage_code,
  output logic low_power_request_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    voltage_code = 8'hb2;
    low_power_request_n = 1'b1;
  end
  task automatic jump(input logic [7:0] v);
    @(negedge clk) voltage_code = v;
  endtask
  task automatic lp_req();
    @(negedge clk) low_power_request_n = 1'b0;
  endtask
  // A held request is dropped first so the move never runs in low power.
  task automatic move_to(input logic [7:0] v);
    logic lp;
    lp = !low_power_request_n;
    @(negedge clk) low_power_request_n = 1'b1;
    while (voltage_code != v)
    begin
      repeat (GAP) @(negedge clk);
      voltage_code = (v > voltage_code) ? voltage_code + 8'h01 : voltage_code - 8'h01;
    end
    if (lp)
    begin
      // The last step settles within GAP cycles; the hold counts from there.
      repeat (GAP + LP_GAP) @(negedge clk);
      low_power_request_n = 1'b0;
    end
  endtask
endmodule // vcdec_cpu_model
`default_nettype wire

//--- sim/tb_top.sv
// Self-checking bench for the voltage code decoder.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic enable_in = 1'b0;
  logic [7:0] voltage_code, ref_level;
  logic low_power_request_n, regulating, shutdown, transition_active;
  logic overcurrent_protect_raised, overvoltage_protect_max, low_power_mode;
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  vcdec_top #(.LP_HOLD_CYCLES(16'h0014), .STEP_CYCLES(16'h0004)) DUT (.clk(clk), .rst_b(rst_b),
    .voltage_code(voltage_code), .low_power_request_n(low_power_request_n),
    .enable_in(enable_in), .ref_level(ref_level), .regulating(regulating),
    .shutdown(shutdown), .transition_active(transition_active),
    .overcurrent_protect_raised(overcurrent_protect_raised),
    .overvoltage_protect_max(overvoltage_protect_max), .low_power_mode(low_power_mode));
  vcdec_cpu_model cpu (.clk(clk), .voltage_code(voltage_code),
    .low_power_request_n(low_power_request_n));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Flags are judged mid-move, then the settled reference.
  task automatic t_move(input logic [7:0] code, input logic [7:0] flags, input logic [7:0] r);
    int n;
    logic [7:0] seen;
    n = 0;
    fork
      cpu.move_to(code);
      begin
        repeat (12) @(negedge clk);
        seen = {6'h00, overvoltage_protect_max, overcurrent_protect_raised};
        chk(seen, flags, "flags");
      end
    join
    while (ref_level !== r && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    chk(ref_level, r, "ref");
    chk({7'h00, transition_active}, 8'h00, "busy");
  endtask
  task automatic t_off(input logic [7:0] code, input logic [7:0] exp);
    cpu.jump(code);
    repeat (4) @(negedge clk);
    chk({6'h00, shutdown, regulating}, exp, "off");
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      summarize();
    end
  end
  initial
  begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    // The code is presented before enable so that the first decode is the wanted one.
    cpu.jump(8'h78);
    repeat (2) @(negedge clk);
    enable_in = 1'b1;
    repeat (4) @(negedge clk);
    chk(ref_level, 8'h8a, "start");
    t_move(8'h79, 8'h02, 8'h89);
    t_move(8'h80, 8'h02, 8'h82);
    t_move(8'h7f, 8'h03, 8'h83);
    t_move(8'hb2, 8'h02, 8'h50);
    cpu.lp_req();
    t_move(8'hb1, 8'h03, 8'h51);
    repeat (60) @(negedge clk);
    chk({7'h00, low_power_mode}, 8'h01, "lp");
    t_off(8'hfe, 8'h02);
    chk(ref_level, 8'h00, "offref");
    t_off(8'h78, 8'h02);
    enable_in = 1'b0;
    t_off(8'h78, 8'h00);
    enable_in = 1'b1;
    repeat (3) @(negedge clk);
    chk(ref_level, 8'h8a, "restart");
    t_off(8'hff, 8'h02);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
